// ### rtl/pin_mux.sv
`timescale 1ns/1ns
`include "pin_mux_cfg.svh"
module pin_mux #(
	parameter int LOCK_DUMMY = 0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] boot_select_straps,
	input wire logic [1:0] core_ratio_straps,
	input wire logic [15:0] muxed_addr_data_pins_in,
	output logic [15:0] muxed_addr_data_pins_out,
	output logic [15:0] muxed_addr_data_pins_oe_n,
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic core_running,
	output pin_mux_pkg::boot_mode_t boot_mode,
	output pin_mux_pkg::core_ratio_t core_ratio
);
	import pin_mux_pkg::*;

	logic [31:0] system_control_reg;
	logic [3:0] pp_ctrl;
	logic [23:0] pp_addr;
	logic [15:0] pp_wdata;
	logic [15:0] pp_rdata;
	logic [15:0] flag_out;
	logic [15:0] flag_oe;
	logic [15:0] flag_in;
	logic ratio_reserved;
	logic wr_pend;
	logic [11:0] wr_addr;
	logic start_req;
	pp_state_t state;
	logic [1:0] phase_cnt;
	logic [31:0] status_word;
	logic [31:0] next_rdata;

	strap_latch u_straps (
		.hclk(hclk),
		.hresetn(hresetn),
		.boot_select_straps(boot_select_straps),
		.core_ratio_straps(core_ratio_straps),
		.boot_mode(boot_mode),
		.core_ratio(core_ratio),
		.ratio_reserved(ratio_reserved),
		.core_running(core_running)
	);

	// Swap byte halves between pin order and flag order
	function automatic logic [15:0] swap_halves(input logic [15:0] v);
		swap_halves = {v[7:0], v[15:8]};
	endfunction : swap_halves

	wire pp_enabled = pp_ctrl[`PP_EN_BIT];
	wire pp_wide = pp_ctrl[`PP_WIDE_BIT];
	wire flag_mode = system_control_reg[`SYS_FLAG_MODE_BIT] && !pp_enabled;
	wire busy = (state != PP_IDLE);
	wire bus_take = hsel && hready && htrans[1];
	wire [11:0] rd_addr = haddr[11:0];

	// Pin values for each phase
	wire [15:0] addr_phase = pp_wide ? pp_addr[15:0] : pp_addr[23:8];
	wire [15:0] data_phase = pp_wide ? pp_wdata : {pp_addr[7:0], pp_wdata[7:0]};
	wire [15:0] data_oe_n = pp_ctrl[`PP_WRITE_BIT] ? 16'h0000 : (pp_wide ? 16'hFFFF : 16'h00FF);
	wire [15:0] flag_pins = swap_halves(flag_out);
	wire [15:0] flag_pins_oe_n = ~swap_halves(flag_oe);

	wire [15:0] next_pins = flag_mode ? flag_pins :
		(state == PP_ADDR) ? addr_phase :
		(state == PP_DATA) ? data_phase : 16'h0000;
	wire [15:0] next_oe_n = flag_mode ? flag_pins_oe_n :
		(state == PP_ADDR) ? 16'h0000 :
		(state == PP_DATA) ? data_oe_n : 16'hFFFF;

	// Status fields placed at their configured bit positions
	always_comb begin
		status_word = 32'h00000000;
		status_word[`ST_BUSY_BIT] = busy;
		status_word[`ST_RUN_BIT] = core_running;
		status_word[`ST_BOOT_LSB +: 2] = boot_mode;
		status_word[`ST_RATIO_LSB +: 2] = core_ratio;
		status_word[`ST_RSVD_BIT] = ratio_reserved;
	end

	// Read decode; unmapped offsets read as zero
	always_comb begin
		if (rd_addr == `OFS_SYS_CTRL) begin
			next_rdata = system_control_reg;
		end else if (rd_addr == `OFS_PP_CTRL) begin
			next_rdata = {28'h0000000, pp_ctrl};
		end else if (rd_addr == `OFS_PP_ADDR) begin
			next_rdata = {8'h00, pp_addr};
		end else if (rd_addr == `OFS_PP_DATA) begin
			next_rdata = {16'h0000, pp_rdata};
		end else if (rd_addr == `OFS_FLAG_OUT) begin
			next_rdata = {16'h0000, flag_out};
		end else if (rd_addr == `OFS_FLAG_OE) begin
			next_rdata = {16'h0000, flag_oe};
		end else if (rd_addr == `OFS_FLAG_IN) begin
			next_rdata = {16'h0000, flag_in};
		end else if (rd_addr == `OFS_STATUS) begin
			next_rdata = status_word;
		end else begin
			next_rdata = 32'h00000000;
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= bus_take && hwrite;
			wr_addr <= haddr[11:0];
			if (bus_take && !hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	wire wr_sys = wr_pend && (wr_addr == `OFS_SYS_CTRL);
	wire wr_ctrl = wr_pend && (wr_addr == `OFS_PP_CTRL);
	wire wr_paddr = wr_pend && (wr_addr == `OFS_PP_ADDR);
	wire wr_pdata = wr_pend && (wr_addr == `OFS_PP_DATA);
	wire wr_fout = wr_pend && (wr_addr == `OFS_FLAG_OUT);
	wire wr_foe = wr_pend && (wr_addr == `OFS_FLAG_OE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			system_control_reg <= `SYS_CTRL_RST;
			pp_ctrl <= `PP_CTRL_RST;
			pp_addr <= 24'h000000;
			pp_wdata <= 16'h0000;
			flag_out <= 16'h0000;
			flag_oe <= 16'h0000;
		end else begin
			if (wr_sys) system_control_reg <= hwdata;
			if (wr_ctrl && !busy) pp_ctrl <= {1'b0, hwdata[2:0]};
			if (wr_paddr && !busy) pp_addr <= hwdata[23:0];
			if (wr_pdata && !busy) pp_wdata <= hwdata[15:0];
			if (wr_fout) flag_out <= hwdata[15:0];
			if (wr_foe) flag_oe <= hwdata[15:0];
		end
	end

	// A start request launches one transfer when the port is enabled and idle and the core is running
	assign start_req = wr_ctrl && hwdata[`PP_START_BIT] && hwdata[`PP_EN_BIT] && !busy
		&& core_running;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= PP_IDLE;
			phase_cnt <= 2'h0;
		end else begin
			case (state)
				PP_IDLE: begin
					phase_cnt <= 2'h0;
					if (start_req) state <= PP_ADDR;
				end
				PP_ADDR: begin
					phase_cnt <= phase_cnt + 2'h1;
					if (phase_cnt == 2'(`ALE_CYCLES - 1)) begin
						phase_cnt <= 2'h0;
						state <= PP_DATA;
					end
				end
				PP_DATA: begin
					phase_cnt <= phase_cnt + 2'h1;
					if (phase_cnt == 2'(`STROBE_CYCLES - 1)) state <= PP_DONE;
				end
				PP_DONE: state <= PP_IDLE;
				default: state <= PP_IDLE;
			endcase
		end
	end

	// Registered pin drive; strobes and ALE always driven, never released
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			muxed_addr_data_pins_out <= 16'h0000;
			muxed_addr_data_pins_oe_n <= 16'hFFFF;
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			flag_in <= 16'h0000;
			pp_rdata <= 16'h0000;
		end else begin
			muxed_addr_data_pins_out <= next_pins;
			muxed_addr_data_pins_oe_n <= next_oe_n;
			ale <= !flag_mode && (state == PP_ADDR);
			rd_n <= !(!flag_mode && state == PP_DATA && !pp_ctrl[`PP_WRITE_BIT]);
			wr_n <= !(!flag_mode && state == PP_DATA && pp_ctrl[`PP_WRITE_BIT]);
			flag_in <= swap_halves(muxed_addr_data_pins_in);
			if (state == PP_DONE && !pp_ctrl[`PP_WRITE_BIT]) begin
				pp_rdata <= pp_wide ? muxed_addr_data_pins_in :
					{8'h00, muxed_addr_data_pins_in[7:0]};
			end
		end
	end
endmodule : pin_mux

// ### rtl/pin_mux_cfg.svh
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
// Register byte offsets
`define OFS_SYS_CTRL 12'h000
`define OFS_PP_CTRL 12'h004
`define OFS_PP_ADDR 12'h008
`define OFS_PP_DATA 12'h00C
`define OFS_FLAG_OUT 12'h010
`define OFS_FLAG_OE 12'h014
`define OFS_FLAG_IN 12'h018
`define OFS_STATUS 12'h01C
// Field positions
`define SYS_FLAG_MODE_BIT 20
`define PP_EN_BIT 0
`define PP_WIDE_BIT 1
`define PP_WRITE_BIT 2
`define PP_START_BIT 3
`define ST_BUSY_BIT 0
`define ST_RUN_BIT 1
`define ST_BOOT_LSB 4
`define ST_RATIO_LSB 8
`define ST_RSVD_BIT 11
// Reset values
`define SYS_CTRL_RST 32'h00000000
`define PP_CTRL_RST 4'h0
// Timing
`define LOCK_CYCLES 4096
`define ALE_CYCLES 2
`define STROBE_CYCLES 3
`endif

// ### rtl/pin_mux_pkg.sv
package pin_mux_pkg;
	typedef enum logic [1:0] {
		BOOT_SPI_SLAVE = 2'h0,
		BOOT_SPI_MASTER = 2'h1,
		BOOT_PARALLEL_EPROM = 2'h2,
		BOOT_INTERNAL_ROM = 2'h3
	} boot_mode_t;
	typedef enum logic [1:0] {
		RATIO_3_TO_1 = 2'h0,
		RATIO_16_TO_1 = 2'h1,
		RATIO_8_TO_1 = 2'h2,
		RATIO_RESERVED = 2'h3
	} core_ratio_t;
	typedef enum logic [3:0] {
		PP_IDLE = 4'b0001,
		PP_ADDR = 4'b0010,
		PP_DATA = 4'b0100,
		PP_DONE = 4'b1000
	} pp_state_t;
endpackage : pin_mux_pkg

// ### rtl/strap_latch.sv
`timescale 1ns/1ns
`include "pin_mux_cfg.svh"
module strap_latch (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] boot_select_straps,
	input wire logic [1:0] core_ratio_straps,
	output pin_mux_pkg::boot_mode_t boot_mode,
	output pin_mux_pkg::core_ratio_t core_ratio,
	output logic ratio_reserved,
	output logic core_running
);
	import pin_mux_pkg::*;
	localparam int LOCK_W = 13;
	logic [LOCK_W-1:0] lock_count;
	logic captured;
	// Straps are sampled on the first edge after release, then frozen
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			captured <= 1'b0;
			boot_mode <= BOOT_SPI_SLAVE;
			core_ratio <= RATIO_3_TO_1;
			ratio_reserved <= 1'b0;
		end else if (!captured) begin
			captured <= 1'b1;
			boot_mode <= boot_mode_t'(boot_select_straps);
			core_ratio <= core_ratio_t'(core_ratio_straps);
			ratio_reserved <= (core_ratio_straps == 2'h3);
		end
	end
	// Hold execution off until the lock interval has elapsed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_count <= '0;
			core_running <= 1'b0;
		end else if (lock_count == LOCK_W'(`LOCK_CYCLES - 1)) begin
			core_running <= 1'b1;
		end else begin
			lock_count <= lock_count + LOCK_W'(1);
		end
	end
endmodule : strap_latch

// ### tb/ext_latch_mem.sv
`timescale 1ns/1ns
module ext_latch_mem (
	input wire logic hclk,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wide,
	input wire logic [15:0] pins,
	output logic [15:0] lat,
	output logic [15:0] drv,
	output logic [15:0] drv_en
);
	always_ff @(posedge hclk) begin
		if (ale) lat <= pins;
	end
	// Read data is the inverted latched address; narrow mode answers on the low lane only
	assign drv = ~lat;
	assign drv_en = rd_n ? 16'h0000 : (wide ? 16'hFFFF : 16'h00FF);
endmodule : ext_latch_mem

// ### tb/pin_mux_properties.sv
`timescale 1ns/1ns
module pin_mux_properties (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] boot_select_straps,
	input wire logic [1:0] core_ratio_straps,
	input wire logic [15:0] muxed_addr_data_pins_out,
	input wire logic [15:0] muxed_addr_data_pins_oe_n,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic core_running,
	input pin_mux_pkg::boot_mode_t boot_mode,
	input pin_mux_pkg::core_ratio_t core_ratio
);
	import pin_mux_pkg::*;
	logic [12:0] cnt;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cnt <= 13'h0000;
		else if (cnt != 13'h1000) cnt <= cnt + 13'h0001;
	end
	a_boot_capture: assert property (cnt == 13'h0001 |-> boot_mode == $past(boot_select_straps))
		else $error("boot mode differs from straps");
	a_ratio_capture: assert property (cnt == 13'h0001 |-> core_ratio == $past(core_ratio_straps))
		else $error("ratio differs from straps");
	a_mode_hold: assert property (cnt > 13'h0001 |-> $stable(boot_mode) && $stable(core_ratio))
		else $error("strap decode changed");
	a_lock_wait: assert property (core_running == (cnt >= 13'h1000))
		else $error("run flag at wrong cycle");
	a_ale_length: assert property ($rose(ale) |=> ale ##1 !ale)
		else $error("latch enable length wrong");
	a_ale_addr_hold: assert property (ale && $past(ale) |-> $stable(muxed_addr_data_pins_out))
		else $error("address moved under latch enable");
	a_ale_drive: assert property (ale |-> muxed_addr_data_pins_oe_n == 16'h0000 && rd_n && wr_n)
		else $error("address phase not driven");
	a_strobe_len: assert property ($fell(ale) |-> (rd_n != wr_n) [*3] ##1 (rd_n && wr_n))
		else $error("strobe length wrong");
	a_strobe_excl: assert property (rd_n || wr_n)
		else $error("both strobes low");
endmodule : pin_mux_properties
bind pin_mux pin_mux_properties i_props (.hclk(hclk), .hresetn(hresetn),
	.boot_select_straps(boot_select_straps), .core_ratio_straps(core_ratio_straps),
	.muxed_addr_data_pins_out(muxed_addr_data_pins_out),
	.muxed_addr_data_pins_oe_n(muxed_addr_data_pins_oe_n), .ale(ale), .rd_n(rd_n),
	.wr_n(wr_n), .core_running(core_running), .boot_mode(boot_mode), .core_ratio(core_ratio));

// ### tb/pin_mux_tb.sv
`timescale 1ns/1ns
module pin_mux_tb;
	import pin_mux_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_due = 1'b0;
	logic wide = 1'b0, fen = 1'b0;
	logic [1:0] htrans = 2'h0, bs = 2'h0, cs = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h4F8C3604, hrdata, a, d;
	logic [15:0] fv = 16'h0000, po, oe_n, pin, lat, drv, drv_en;
	logic hreadyout, hresp, ale, rd_n, wr_n, run;
	boot_mode_t bm;
	core_ratio_t cr;
	logic [31:0] exp_q[$];
	int fails = 0, tests_run = 0, cyc = 0;
	always #10 hclk = ~hclk;
	// Released lines float high through the pull-ups, or take fv while fen is set
	assign pin = (~oe_n & po) | (oe_n & drv_en & drv) | (oe_n & ~drv_en & (fen ? fv : 16'hFFFF));
	pin_mux i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .boot_select_straps(bs), .core_ratio_straps(cs),
		.muxed_addr_data_pins_in(pin), .muxed_addr_data_pins_out(po),
		.muxed_addr_data_pins_oe_n(oe_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.core_running(run), .boot_mode(bm), .core_ratio(cr));
	ext_latch_mem i_mem (.hclk(hclk), .ale(ale), .rd_n(rd_n), .wide(wide), .pins(pin),
		.lat(lat), .drv(drv), .drv_en(drv_en));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task check(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask : check
	task end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task xfer(input logic w, input logic [31:0] ad, input logic [31:0] dv);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dv;
		rd_due <= !w;
		if (!w) exp_q.push_back(dv);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_due <= 1'b0;
	endtask : xfer
	task settle;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
	endtask : settle
	always @(posedge hclk) begin
		if (rd_due === 1'b1) begin
			check(hrdata, exp_q.pop_front());
			check({hreadyout, hresp}, 2'b10);
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		// Every boot code, ratio codes other than the reserved one
		for (int i = 0; i < 4; i++) begin
			bs <= 2'(i);
			cs <= 2'(i % 3);
			hresetn <= 1'b0;
			repeat (5) @(posedge hclk);
			hresetn <= 1'b1;
			repeat (2) @(posedge hclk);
			bs <= ~2'(i);
			cs <= 2'((i + 1) % 3);
			@(negedge hclk);
			check(bm, i);
			check(cr, i % 3);
			xfer(1'b0, 32'h1C, ((i % 3) << 8) | (i << 4));
		end
		repeat (4100) @(posedge hclk);
		check(run, 1'b1);
		xfer(1'b1, 32'h20, rnd());
		xfer(1'b0, 32'h20, 32'h0);
		d = rnd();
		xfer(1'b1, 32'h0, 32'h00100000);
		xfer(1'b1, 32'h14, 32'hFFFF);
		xfer(1'b1, 32'h10, d);
		settle();
		check(po, {d[7:0], d[15:8]});
		check(oe_n, 16'h0000);
		xfer(1'b1, 32'h4, 32'h1);
		settle();
		check(oe_n, 16'hFFFF);
		xfer(1'b1, 32'h4, 32'h0);
		xfer(1'b1, 32'h14, 32'h0);
		fv <= d[31:16];
		fen <= 1'b1;
		settle();
		xfer(1'b0, 32'h18, {16'h0, d[23:16], d[31:24]});
		fen <= 1'b0;
		xfer(1'b1, 32'h0, 32'h0);
		for (int k = 0; k < 4; k++) begin
			a = rnd() & 32'hFFFFFF;
			d = rnd();
			wide <= k[1];
			xfer(1'b1, 32'h8, a);
			xfer(1'b1, 32'hC, d);
			xfer(1'b1, 32'h4, {28'h0, 1'b1, k[0], k[1], 1'b1});
			do @(negedge hclk); while (ale !== 1'b1);
			check(po, k[1] ? a[15:0] : a[23:8]);
			do @(negedge hclk); while (ale === 1'b1);
			check({rd_n, wr_n}, k[0] ? 2'b10 : 2'b01);
			if (k[0]) begin
				check(po, k[1] ? d[15:0] : {a[7:0], d[7:0]});
			end else begin
				check(oe_n, k[1] ? 16'hFFFF : 16'h00FF);
				if (!k[1]) check(po[15:8], a[7:0]);
			end
			do @(negedge hclk); while (!(rd_n && wr_n));
			check(lat, k[1] ? a[15:0] : a[23:8]);
			settle();
			if (!k[0]) xfer(1'b0, 32'hC, k[1] ? {16'h0, ~a[15:0]} : {24'h0, ~a[15:8]});
		end
		end_sim();
	end
endmodule : pin_mux_tb
